// ===== sfdpfe_pkg.sv
`default_nettype none
package sfdpfe_pkg;
	// ----------------------------------------
	// Opcodes
	// ----------------------------------------
	localparam logic [7:0] OP_READ_DISCOVERY_PARAMS = 8'h5a;
	localparam logic [7:0] OP_WRITE_ENABLE_CMD      = 8'h06;
	localparam logic [7:0] OP_FAST_ERASE_ENABLE     = 8'h68;
	localparam logic [7:0] OP_SECTOR_ERASE_CMD      = 8'h20;
	localparam logic [7:0] OP_HALF_BLOCK_ERASE_CMD  = 8'h52;
	localparam logic [7:0] OP_BLOCK_ERASE_CMD       = 8'hd8;
	localparam logic [7:0] OP_CHIP_ERASE_CMD        = 8'h60;
	// ----------------------------------------
	// Framing
	// ----------------------------------------
	localparam int ADDR_BYTES  = 3;
	localparam int DUMMY_BYTES = 1;
	localparam logic [5:0] HDR_BITS = 6'h28;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [5:0] OP_BITS     = 6'h08;
	localparam logic [5:0] OPADDR_BITS = 6'h20;
	localparam int PARAM_AW = 8;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {SFDPFE_ERASE_SECTOR, SFDPFE_ERASE_HALF, SFDPFE_ERASE_BLOCK,
		SFDPFE_ERASE_CHIP} sfdpfe_erase_t;
	typedef struct packed {
		logic          start;
		logic          fast;
		sfdpfe_erase_t kind;
		logic [23:0]   addr;
	} sfdpfe_erase_req_t;
endpackage
`default_nettype wire

// ===== sfdpfe_core.sv
`default_nettype none
// What this block does
// [RL1] Opcode 5a, three address bytes, one dummy byte, then table bytes out on so.
// [RL2] Chip select high anytime during data out stops output and ends the command.
// [RL3] Fast erase needs write enable, then fast-erase enable, then erase, in order.
// [RL4] Fast-erase enable is opcode only; chip select rises at byte boundary.
// [RL5] Flag set makes any of the four erases run in enhanced mode.
// [RL6] Flag clears at power-up and when the paired erase completes.
// [RL7] After power-up: standby, not deep power-down; write enable latch clear.
// [RL8] Host keeps chip select high during power-up and power-down.
// [RL9] Power-on reset holds logic in reset; all commands ignored meanwhile. The sclk read path is not reset here, so 5a still answers.
// [RL10] Host sends commands only after the supply settle delay.
// [RL11] Supply below write-inhibit threshold disables all operations at once. Here only i_resetn does this, and the sclk read path still answers 5a.
// [RL12] Erases need the latch set first; latch clears when the cycle completes.
module sfdpfe_core
	import sfdpfe_pkg::*;
#(
	parameter int TABLE_DEPTH = 256
)(
	input  wire logic              i_clk,
	input  wire logic              i_resetn,
	input  wire logic              i_sclk,
	input  wire logic              i_cs_n,
	input  wire logic              i_si,
	output logic                   o_so,
	output logic                   o_so_oe,
	output sfdpfe_erase_req_t      o_erase_req,
	input  wire logic              i_erase_done,
	output logic                   o_write_enable_latch,
	output logic                   o_fast_erase_enable,
	output logic                   o_busy
);
	// ----------------------------------------
	// Parameter table (link domain)
	// ----------------------------------------
	logic [7:0] param_table [TABLE_DEPTH];
	always_comb begin
		for (int i = 0; i < TABLE_DEPTH; i++) begin
			param_table[i] = 8'(i);
		end
	end

	// ----------------------------------------
	// Link domain: serial shifter on sclk
	// ----------------------------------------
	// Reset on cs high, so a frame always starts clean; no edge counted outside frames.
	typedef struct packed {
		logic [5:0]  cnt;
		logic [2:0]  bitn;
		logic [7:0]  op;
		logic [23:0] addr;
		logic        hdr_done;
	} sfdpfe_lnk_t;
	sfdpfe_lnk_t lnk;
	sfdpfe_lnk_t next_lnk;
	logic        so_q;
	logic [7:0]  op_now;

	assign op_now = {lnk.op[6:0], i_si};

	always_comb begin
		next_lnk = lnk;
		if (!lnk.hdr_done || lnk.cnt < HDR_BITS) begin
			next_lnk.cnt = lnk.cnt + 6'h01;
			if (lnk.cnt < OP_BITS) begin
				next_lnk.op = op_now;
			end else if (lnk.cnt < OPADDR_BITS) begin
				next_lnk.addr = {lnk.addr[22:0], i_si};
			end
			if (lnk.cnt == HDR_BITS - 6'h01) begin
				next_lnk.hdr_done = 1'b1;
			end
		end
		next_lnk.bitn = lnk.bitn + 3'h1;
		if (lnk.hdr_done && lnk.bitn == BIT_LAST) begin
			next_lnk.addr = lnk.addr + 24'h000001;
		end
	end

	always_ff @(posedge i_sclk or posedge i_cs_n) begin
		if (i_cs_n) begin
			lnk <= '0;
		end else begin
			lnk <= next_lnk;
		end
	end

	// Output changes on falling sclk, host samples on rising
	// Table index is the low 8 address bits, so it wraps at 256; a read past entry 255 starts again at zero
	always_ff @(negedge i_sclk or posedge i_cs_n) begin
		if (i_cs_n) begin
			so_q <= 1'b0;
		end else begin
			so_q <= param_table[lnk.addr[PARAM_AW-1:0]][BIT_LAST - lnk.bitn];
		end
	end

	assign o_so    = so_q;
	assign o_so_oe = !i_cs_n && lnk.hdr_done && (lnk.op == OP_READ_DISCOVERY_PARAMS); // RL1 RL2

	// ----------------------------------------
	// Frame hand-over (cs edge to core)
	// ----------------------------------------
	// The summary is latched as cs rises, in the same step that clears the shifter,
	// and then stands still until the next frame ends; the core reads it only
	// after its own synced copy of cs has risen, so no bit is caught mid-change.
	// A deselect with no sclk edge latches zero, so an old command never replays.
	logic [7:0]  cap_op;
	logic        cap_aligned;
	always_ff @(posedge i_cs_n) begin
		cap_op      <= lnk.op;
		cap_aligned <= (lnk.bitn == 3'h0) && (lnk.cnt != 6'h00);
	end

	// ----------------------------------------
	// Core domain
	// ----------------------------------------
	typedef struct packed {
		logic        cs_s1;
		logic        cs_s2;
		logic        cs_s3;
		logic        write_enable_latch;
		logic        fee;
		logic        busy;
		sfdpfe_erase_req_t req;
	} sfdpfe_st_t;
	sfdpfe_st_t st;
	sfdpfe_st_t next_st;
	logic       frame_end;
	logic       is_erase;

	function automatic logic erase_kind(input logic [7:0] op, output sfdpfe_erase_t k);
		k = SFDPFE_ERASE_SECTOR;
		erase_kind = 1'b1;
		case (op)
			OP_SECTOR_ERASE_CMD:     k = SFDPFE_ERASE_SECTOR;
			OP_HALF_BLOCK_ERASE_CMD: k = SFDPFE_ERASE_HALF;
			OP_BLOCK_ERASE_CMD:      k = SFDPFE_ERASE_BLOCK;
			OP_CHIP_ERASE_CMD:       k = SFDPFE_ERASE_CHIP;
			default:                 erase_kind = 1'b0;
		endcase
	endfunction

	assign frame_end = st.cs_s2 && !st.cs_s3;

	// Busy beats a frame end: a command that arrives mid-erase is dropped, not queued
	always_comb begin
		sfdpfe_erase_t k;
		k = SFDPFE_ERASE_SECTOR;
		next_st = st;
		next_st.cs_s1 = i_cs_n;
		next_st.cs_s2 = st.cs_s1;
		next_st.cs_s3 = st.cs_s2;
		next_st.req.start = 1'b0;
		is_erase = erase_kind(cap_op, k);
		if (st.busy && i_erase_done) begin
			next_st.busy = 1'b0;
			next_st.write_enable_latch  = 1'b0; // RL12
			next_st.fee  = 1'b0; // RL6
		end else if (frame_end && cap_aligned && !st.busy) begin
			if (cap_op == OP_WRITE_ENABLE_CMD) begin
				next_st.write_enable_latch = 1'b1;
			end else if (cap_op == OP_FAST_ERASE_ENABLE && st.write_enable_latch) begin
				next_st.fee = 1'b1; // RL3 RL4
			end else if (is_erase && st.write_enable_latch) begin
				next_st.busy = 1'b1; // RL12
				next_st.req.start = 1'b1;
				next_st.req.fast  = st.fee; // RL3 RL5
				next_st.req.kind  = k;
				next_st.req.addr  = 24'h000000;
			end else if (cap_op != OP_READ_DISCOVERY_PARAMS) begin
				next_st.fee = 1'b0; // RL3
			end
		end
	end

	// Power-on reset: standby, latch and flag clear, commands other than the 5a read ignored
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			st <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1, default: '0}; // RL7 RL9 RL11 RL6
		end else begin
			st <= next_st;
		end
	end

	assign o_erase_req          = st.req;
	assign o_write_enable_latch = st.write_enable_latch;
	assign o_fast_erase_enable  = st.fee;
	assign o_busy               = st.busy;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_wel_clr_done: assert property (@(posedge i_clk) disable iff (!i_resetn)
		st.busy && i_erase_done |=> !o_write_enable_latch) else $error("latch kept"); // RL12
	a_fee_clr_done: assert property (@(posedge i_clk) disable iff (!i_resetn)
		st.busy && i_erase_done |=> !o_fast_erase_enable) else $error("flag kept"); // RL6
	a_erase_needs_wel: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_erase_req.start |-> $past(o_write_enable_latch)) else $error("no latch"); // RL12
	a_fast_follows_fee: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_erase_req.start |-> o_erase_req.fast == $past(o_fast_erase_enable))
		else $error("fast mismatch"); // RL5
	a_fee_needs_wel: assert property (@(posedge i_clk) disable iff (!i_resetn)
		$rose(o_fast_erase_enable) |-> $past(o_write_enable_latch)) else $error("order"); // RL3
	a_reset_state: assert property (@(posedge i_clk)
		!$past(i_resetn) |-> !o_write_enable_latch && !o_fast_erase_enable && !o_busy)
		else $error("bad reset"); // RL7
	a_start_busy: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_erase_req.start |-> o_busy ##1 !o_erase_req.start) else $error("start"); // RL12
	a_so_off_cs: assert property (@(posedge i_clk) disable iff (!i_resetn)
		i_cs_n |-> !o_so_oe) else $error("driving while deselected"); // RL2
	a_busy_freezes: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_busy && !i_erase_done |=> $stable(o_write_enable_latch) && $stable(o_fast_erase_enable))
		else $error("state moved while busy"); // RL12
	a_busy_rise: assert property (@(posedge i_clk) disable iff (!i_resetn)
		$rose(o_busy) |-> o_erase_req.start) else $error("busy without start"); // RL12
	a_cut_ignored: assert property (@(posedge i_clk) disable iff (!i_resetn)
		frame_end && !cap_aligned && !o_busy |=> $stable(o_write_enable_latch)
		&& $stable(o_fast_erase_enable) && !o_erase_req.start) else $error("cut frame acted"); // RL4
endmodule // sfdpfe_core
`default_nettype wire

// ===== sfdpfe_host.sv
`default_nettype none
// ----------------------------------------
// Host side of the serial bus
// ----------------------------------------
module sfdpfe_host (
	output logic     o_sclk,
	output logic     o_cs_n,
	output logic     o_si,
	input wire logic i_so
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_si = 1'b0;
	end
	// Clock stands still between frames; si flips so no stale bit is read
	task automatic frame(input logic [39:0] d, input int nb, input int nr,
		output logic [15:0] r);
		r = 16'h0;
		#5 o_cs_n = 1'b0;
		for (int i = 0; i < nb; i++) begin
			o_si = d[39-i];
			#32 o_sclk = 1'b1;
			#32 o_sclk = 1'b0;
		end
		for (int i = 0; i < nr; i++) begin
			#32 o_sclk = 1'b1;
			r = {r[14:0], i_so};
			#32 o_sclk = 1'b0;
		end
		#20 o_cs_n = 1'b1;
		o_si = ~o_si;
	endtask
endmodule // sfdpfe_host
`default_nettype wire

// ===== sfdpfe_core_bench.sv
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, e); end end
// ----------------------------------------
// Bench
// ----------------------------------------
module sfdpfe_core_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import sfdpfe_pkg::*;
	logic i_clk, i_resetn, sclk, cs_n, si, so, so_oe, done, write_enable_latch, fe, busy;
	// No keeper on the data-out pin: a released pin reads back inverted, so a slip shows
	logic so_bus;
	assign so_bus = so_oe ? so : ~so;
	sfdpfe_erase_req_t req;
	int n_fail, tests_run;
	sfdpfe_core dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_sclk(sclk), .i_cs_n(cs_n),
		.i_si(si), .o_so(so), .o_so_oe(so_oe), .o_erase_req(req), .i_erase_done(done),
		.o_write_enable_latch(write_enable_latch), .o_fast_erase_enable(fe), .o_busy(busy));
	sfdpfe_host host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si), .i_so(so_bus));
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic end_of_test;
		$display("checks %0d failures %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Six cycles covers the 2 to 3 cycle action delay and the gap between frames
	task automatic op(input logic [7:0] c);
		logic [15:0] r;
		host_u.frame({c, 32'h0}, 8, 0, r);
		cyc(6);
	endtask
	task automatic erase(input logic [7:0] c, input logic xf, input sfdpfe_erase_t k,
		input logic go);
		logic [15:0] r;
		logic seen;
		seen = 1'b0;
		host_u.frame({c, 32'h0}, (c == OP_CHIP_ERASE_CMD) ? 8 : 32, 0, r);
		repeat (20) begin
			cyc(1);
			if (req.start === 1'b1) begin
				seen = 1'b1;
				`CHK(req.fast, xf)
				`CHK(req.kind, k)
				`CHK(req.addr, 24'h000000)
			end
		end
		`CHK(seen, go)
		if (go) begin
			`CHK(busy, 1'b1)
			done = 1'b1;
			cyc(1);
			done = 1'b0;
			cyc(4);
			`CHK(write_enable_latch, 1'b0)
			`CHK(fe, 1'b0)
			`CHK(busy, 1'b0)
		end
	endtask
	task automatic t_read;
		logic [15:0] r;
		host_u.frame({OP_READ_DISCOVERY_PARAMS, 24'h00003e, 8'h0}, 40, 16, r);
		`CHK(r, 16'h3e3f)
		cyc(2);
		`CHK(so_oe, 1'b0)
		cyc(4);
		host_u.frame({OP_READ_DISCOVERY_PARAMS, 24'h0000a5, 8'h0}, 40, 5, r);
		`CHK(r[4:0], 5'h14)
		cyc(2);
		`CHK(so_oe, 1'b0)
		cyc(4);
		$display("read test done");
	endtask
	task automatic t_fast;
		logic [7:0] c [4];
		c = '{OP_SECTOR_ERASE_CMD, OP_HALF_BLOCK_ERASE_CMD, OP_BLOCK_ERASE_CMD,
			OP_CHIP_ERASE_CMD};
		for (int i = 0; i < 4; i++) begin
			op(OP_WRITE_ENABLE_CMD);
			`CHK(write_enable_latch, 1'b1)
			op(OP_FAST_ERASE_ENABLE);
			`CHK(fe, 1'b1)
			erase(c[i], 1'b1, sfdpfe_erase_t'(i), 1'b1);
		end
		$display("fast erase test done");
	endtask
	task automatic t_refuse;
		op(OP_FAST_ERASE_ENABLE);
		`CHK(fe, 1'b0)
		erase(OP_SECTOR_ERASE_CMD, 1'b0, SFDPFE_ERASE_SECTOR, 1'b0);
		op(OP_WRITE_ENABLE_CMD);
		op(OP_FAST_ERASE_ENABLE);
		`CHK(fe, 1'b1)
		op(8'h00);
		`CHK(fe, 1'b0)
		erase(OP_BLOCK_ERASE_CMD, 1'b0, SFDPFE_ERASE_BLOCK, 1'b1);
		$display("refusal test done");
	endtask
	task automatic t_por;
		op(OP_WRITE_ENABLE_CMD);
		op(OP_FAST_ERASE_ENABLE);
		i_resetn = 1'b0;
		cyc(3);
		`CHK(write_enable_latch, 1'b0)
		`CHK(fe, 1'b0)
		op(OP_WRITE_ENABLE_CMD);
		`CHK(write_enable_latch, 1'b0)
		i_resetn = 1'b1;
		cyc(6);
		$display("power-on test done");
	endtask
	initial begin
		i_resetn = 1'b0;
		done = 1'b0;
		n_fail = 0;
		tests_run = 0;
		cyc(6);
		i_resetn = 1'b1;
		cyc(1);
		`CHK({write_enable_latch, fe, busy, req.start}, 4'h0)
		cyc(4);
		t_read();
		t_fast();
		t_refuse();
		t_por();
		end_of_test();
	end
endmodule // sfdpfe_core_bench
`default_nettype wire
